// ### hsls_unit.v
// Execution unit for half-word and signed byte/half-word transfers.
// Assumes one core clock; memory answers data and fault in the cycle
// after the request, never stalls; register values come with issue.
//
// Behaviour
// [RQ1] Execute only when condition field passes
// [RQ2] Immediate offset from bits 11..8 and 3..0
// [RQ3] Up bit adds offset, else subtracts
// [RQ4] Pre uses modified base, post uses old
// [RQ5] Pre-indexed write-back only when W set
// [RQ6] Post-indexed always writes modified base back; the code skips it for a PC base
// [RQ7] Source never sets W with post-index
// [RQ8] S=0,H=1 moves unsigned half-word
// [RQ9] S=1 loads signed byte or half-word
// [RQ10] Source never encodes signed store
// [RQ11] Signed byte sign-extends bit 7
// [RQ12] Signed half sign-extends bit 15
// [RQ13] Unsigned half clears bits 31..16
// [RQ14] Little-endian bytes rise from lanes 7..0
// [RQ15] Little-endian half picks by address bit 1
// [RQ16] Big-endian bytes fall from lanes 31..24
// [RQ17] Big-endian half picks by address bit 1
// [RQ18] Software keeps half-word addresses aligned
// [RQ19] Store repeats low half on both halves
// [RQ20] PC base reads address plus 8
// [RQ21] PC store source gives address plus 12
// [RQ22] Memory fault takes the data abort trap
// [RQ23] Load 3, PC load 5, store 2 cycles
// [RQ24] S=0,H=0 handed over as exchange op
`include "hsls_consts.vh"
`default_nettype none

module hsls_unit #(
  parameter DW = 32
) (
  input wire mclk,
  input wire resetn,
  input wire endian_select_input,
  input wire issue_valid,
  input wire [31:0] issue_instr,
  input wire [31:0] issue_addr,
  input wire [3:0] issue_flags,
  input wire [DW-1:0] base_val,
  input wire [DW-1:0] offset_val,
  input wire [DW-1:0] src_val,
  output reg issue_ready,
  output reg mem_req,
  output reg mem_write,
  output reg mem_half,
  output reg [31:0] mem_addr,
  output reg [DW-1:0] mem_wdata,
  input wire [DW-1:0] mem_rdata,
  input wire mem_abort,
  output reg rd_we,
  output reg [3:0] rd_idx,
  output reg [DW-1:0] rd_data,
  output reg base_we,
  output reg [3:0] base_idx,
  output reg [DW-1:0] base_data,
  output reg abort_trap,
  output reg exchange_op,
  output reg done
);

  // -------------------------------------------------------------
  // States
  // -------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_MEM = 2'h1;
  localparam [1:0] ST_CAP = 2'h2;
  localparam [1:0] ST_TAIL = 2'h3;

  // -------------------------------------------------------------
  // Functions
  // -------------------------------------------------------------
  function cond_pass;
    input [3:0] cc;
    input [3:0] f;
    reg n;
    reg z;
    reg c;
    reg v;
    begin
      n = f[`HSLS_FLAG_N];
      z = f[`HSLS_FLAG_Z];
      c = f[`HSLS_FLAG_C];
      v = f[`HSLS_FLAG_V];
      case (cc)
        4'h0: cond_pass = z;
        4'h1: cond_pass = ~z;
        4'h2: cond_pass = c;
        4'h3: cond_pass = ~c;
        4'h4: cond_pass = n;
        4'h5: cond_pass = ~n;
        4'h6: cond_pass = v;
        4'h7: cond_pass = ~v;
        4'h8: cond_pass = c & ~z;
        4'h9: cond_pass = ~c | z;
        4'hA: cond_pass = n == v;
        4'hB: cond_pass = n != v;
        4'hC: cond_pass = ~z & (n == v);
        4'hD: cond_pass = z | (n != v);
        4'hE: cond_pass = 1'b1;
        default: cond_pass = 1'b0;
      endcase
    end
  endfunction

  // Picks the addressed lane and extends it to a full word
  function [DW-1:0] load_extract;
    input [DW-1:0] d;
    input [1:0] a;
    input big;
    input s;
    input h;
    reg [1:0] k;
    reg [7:0] b;
    reg [15:0] hw;
    reg hi;
    begin
      k = big ? ~a : a; // RQ14 RQ16
      case (k)
        2'h0: b = d[7:0];
        2'h1: b = d[15:8];
        2'h2: b = d[23:16];
        default: b = d[31:24];
      endcase
      hi = big ? ~a[1] : a[1]; // RQ15 RQ17
      hw = hi ? d[31:16] : d[15:0];
      if (!h)
        load_extract = {{24{b[7]}}, b}; // RQ11
      else if (s)
        load_extract = {{16{hw[15]}}, hw}; // RQ12
      else
        load_extract = {16'h0000, hw}; // RQ13
    end
  endfunction

  // -------------------------------------------------------------
  // Endian pin synchroniser
  // -------------------------------------------------------------
  reg big_meta_q;
  reg big_q;

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      big_meta_q <= 1'b0;
      big_q <= 1'b0;
    end
    else
    begin
      big_meta_q <= endian_select_input;
      big_q <= big_meta_q;
    end
  end

  // -------------------------------------------------------------
  // Issue decode
  // -------------------------------------------------------------
  wire [3:0] f_cond = issue_instr[`HSLS_COND_HI:`HSLS_COND_LO];
  wire f_pre = issue_instr[`HSLS_P_BIT];
  wire f_up = issue_instr[`HSLS_U_BIT];
  wire f_imm = issue_instr[`HSLS_I_BIT];
  wire f_wb = issue_instr[`HSLS_W_BIT];
  wire f_load = issue_instr[`HSLS_L_BIT];
  wire [3:0] f_rn = issue_instr[`HSLS_RN_HI:`HSLS_RN_LO];
  wire [3:0] f_rd = issue_instr[`HSLS_RD_HI:`HSLS_RD_LO];
  wire f_s = issue_instr[`HSLS_S_BIT];
  wire f_h = issue_instr[`HSLS_H_BIT];

  wire [7:0] imm8 = {issue_instr[`HSLS_IMMH_HI:`HSLS_IMMH_LO],
                     issue_instr[`HSLS_IMML_HI:`HSLS_IMML_LO]};
  wire [DW-1:0] offset = f_imm ? {{(DW-8){1'b0}}, imm8} : offset_val; // RQ2

  // Program counter base runs ahead of the instruction by the pipeline
  wire base_is_pc = f_rn == `HSLS_PC_IDX;
  wire [DW-1:0] base_eff = base_is_pc ?
    issue_addr + `HSLS_PC_BASE_ADJ : base_val; // RQ20
  wire [DW-1:0] src_eff = (f_rd == `HSLS_PC_IDX) ?
    issue_addr + `HSLS_PC_SRC_ADJ : src_val; // RQ21

  wire [DW-1:0] base_mod = f_up ? base_eff + offset : base_eff - offset; // RQ3
  wire [DW-1:0] xfer_addr = f_pre ? base_mod : base_eff; // RQ4

  // Post-index ignores W; a PC base never writes back
  wire want_wb = (f_pre ? f_wb : 1'b1) & ~base_is_pc; // RQ5 RQ6 RQ20

  wire is_exchange = ~f_s & ~f_h; // RQ24
  wire take = issue_valid & issue_ready;
  wire passes = cond_pass(f_cond, issue_flags);

  // -------------------------------------------------------------
  // Control state
  // -------------------------------------------------------------
  reg [1:0] st_q;
  reg [1:0] cnt_q;
  reg load_q;
  reg s_q;
  reg wb_q;
  reg [1:0] alo_q;
  reg [DW-1:0] wb_val_q;

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q <= ST_IDLE;
      cnt_q <= 2'h0;
      load_q <= 1'b0;
      s_q <= 1'b0;
      wb_q <= 1'b0;
      alo_q <= 2'h0;
      wb_val_q <= `HSLS_ZERO32;
      issue_ready <= 1'b1;
      mem_req <= 1'b0;
      mem_write <= 1'b0;
      mem_half <= 1'b0;
      mem_addr <= `HSLS_ZERO32;
      mem_wdata <= `HSLS_ZERO32;
      rd_we <= 1'b0;
      rd_idx <= 4'h0;
      rd_data <= `HSLS_ZERO32;
      base_we <= 1'b0;
      base_idx <= 4'h0;
      base_data <= `HSLS_ZERO32;
      abort_trap <= 1'b0;
      exchange_op <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      // Pulses fall back unless set again below
      rd_we <= 1'b0;
      base_we <= 1'b0;
      abort_trap <= 1'b0;
      exchange_op <= 1'b0;
      done <= 1'b0;
      mem_req <= 1'b0;
      case (st_q)
        ST_IDLE:
        begin
          if (take)
          begin
            if (!passes)
            begin
              done <= 1'b1; // RQ1
            end
            else if (is_exchange)
            begin
              exchange_op <= 1'b1; // RQ24
            end
            else
            begin
              issue_ready <= 1'b0;
              st_q <= ST_MEM;
              mem_req <= 1'b1;
              mem_write <= ~f_load; // RQ8
              mem_half <= f_h; // RQ8 RQ9
              mem_addr <= xfer_addr; // RQ4
              // Memory enables only the addressed half
              mem_wdata <= {src_eff[15:0], src_eff[15:0]}; // RQ19
              load_q <= f_load;
              s_q <= f_s; // RQ9
              wb_q <= want_wb;
              alo_q <= xfer_addr[1:0];
              wb_val_q <= base_mod;
              rd_idx <= f_rd;
              base_idx <= f_rn;
            end
          end
        end
        ST_MEM:
        begin
          st_q <= ST_CAP;
        end
        ST_CAP:
        begin
          if (mem_abort)
          begin
            // No register or base write-back is made, so the instruction can be restarted
            abort_trap <= 1'b1; // RQ22
            done <= 1'b1;
            st_q <= ST_TAIL;
            cnt_q <= 2'h0;
            issue_ready <= ~load_q;
            if (!load_q)
              st_q <= ST_IDLE;
          end
          else
          begin
            base_we <= wb_q; // RQ5 RQ6
            base_data <= wb_val_q;
            if (load_q)
            begin
              rd_we <= 1'b1;
              rd_data <= load_extract(mem_rdata, alo_q, big_q,
                                      s_q, mem_half);
              st_q <= ST_TAIL;
              if (rd_idx == `HSLS_PC_IDX)
                cnt_q <= `HSLS_PC_TAIL; // RQ23
              else
              begin
                cnt_q <= 2'h0;
                done <= 1'b1; // RQ23
              end
            end
            else
            begin
              // Store finishes after its two bus cycles
              done <= 1'b1; // RQ23
              issue_ready <= 1'b1;
              st_q <= ST_IDLE;
            end
          end
        end
        ST_TAIL:
        begin
          if (cnt_q == 2'h0)
          begin
            issue_ready <= 1'b1;
            st_q <= ST_IDLE;
          end
          else
          begin
            // Pipeline refill after a program counter load
            cnt_q <= cnt_q - 2'h1;
            if (cnt_q == 2'h2)
              done <= 1'b1; // RQ23
          end
        end
        default:
        begin
          st_q <= ST_IDLE;
          issue_ready <= 1'b1;
        end
      endcase
    end
  end

endmodule // hsls_unit

`default_nettype wire

// ### hsls_consts.vh
// Constants for the half-word and signed load/store unit.
// Assumes inclusion by hsls_unit.v only; holds definitions, no logic.
`ifndef HSLS_CONSTS_VH
`define HSLS_CONSTS_VH

// ---------------------------------------------------------------
// Instruction fields
// ---------------------------------------------------------------
`define HSLS_COND_HI 31
`define HSLS_COND_LO 28
`define HSLS_P_BIT 24
`define HSLS_U_BIT 23
`define HSLS_I_BIT 22
`define HSLS_W_BIT 21
`define HSLS_L_BIT 20
`define HSLS_RN_HI 19
`define HSLS_RN_LO 16
`define HSLS_RD_HI 15
`define HSLS_RD_LO 12
`define HSLS_IMMH_HI 11
`define HSLS_IMMH_LO 8
`define HSLS_S_BIT 6
`define HSLS_H_BIT 5
`define HSLS_IMML_HI 3
`define HSLS_IMML_LO 0

// ---------------------------------------------------------------
// Flags and program counter
// ---------------------------------------------------------------
`define HSLS_FLAG_N 3
`define HSLS_FLAG_Z 2
`define HSLS_FLAG_C 1
`define HSLS_FLAG_V 0
`define HSLS_PC_IDX 4'hF
`define HSLS_PC_BASE_ADJ 32'h00000008
`define HSLS_PC_SRC_ADJ 32'h0000000C

// ---------------------------------------------------------------
// Timing and reset values
// ---------------------------------------------------------------
`define HSLS_PC_TAIL 2'h2
`define HSLS_ZERO32 32'h00000000

`endif

// ### hsls_notes_unused.v
`default_nettype none
`default_nettype wire

// ### hsls_mem_model.sv
// Data-side memory model for the transfer unit.
// Assumes one-cycle request pulses; answers in the following cycle.
`default_nettype none
module hsls_mem_model (
  input wire logic mclk,
  input wire logic big,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_abort
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:3] = '{32'h80007F81, 32'h00000000, 32'hC3E51A96, 32'h00000000};
  initial mem_rdata = 32'h00000000;
  initial mem_abort = 1'b0;
  always @(posedge mclk)
  begin
    // Addresses with bit 7 set stand for a missing page
    mem_abort <= mem_req & mem_addr[7];
    // Stale data is inverted so nothing leans on a held bus
    mem_rdata <= mem_req ? mem[mem_addr[3:2]] : ~mem_rdata;
    if (mem_req & mem_write & (mem_addr[1] ^ big))
      mem[mem_addr[3:2]][31:16] <= mem_wdata[31:16];
    else if (mem_req & mem_write)
      mem[mem_addr[3:2]][15:0] <= mem_wdata[15:0];
  end
endmodule // hsls_mem_model
`default_nettype wire

// ### hsls_unit_assertions.sv
// Timing and data checks on the transfer unit's ports.
// Assumes binding into hsls_unit; one clock, async active-low reset.
`default_nettype none
module hsls_unit_assertions #(
  parameter DW = 32
) (
  input wire mclk,
  input wire resetn,
  input wire issue_valid,
  input wire issue_ready,
  input wire [31:0] issue_instr,
  input wire [DW-1:0] base_val,
  input wire mem_req,
  input wire mem_write,
  input wire [31:0] mem_addr,
  input wire [DW-1:0] mem_wdata,
  input wire mem_abort,
  input wire rd_we,
  input wire base_we,
  input wire abort_trap,
  input wire exchange_op,
  input wire done
);
  wire take = issue_valid & issue_ready & (issue_instr[31:28] == 4'hE);
  wire xfer = take & (issue_instr[6] | issue_instr[5]);
  wire [31:0] imm = {24'h000000, issue_instr[11:8], issue_instr[3:0]};
  logic [31:0] exp_q;
  logic chk_q;
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      chk_q <= 1'b0;
    else
      chk_q <= xfer & issue_instr[24] & issue_instr[22] & (issue_instr[19:16] != 4'hF);
  end
  always @(posedge mclk)
    exp_q <= issue_instr[23] ? base_val + imm : base_val - imm;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_cond_pass_req: assert property (xfer |=> mem_req) else $error("no request");
  a_never_cond: assert property (issue_valid && issue_ready && issue_instr[31:28] == 4'hF
    |=> done && !mem_req) else $error("failed condition ran");
  a_exchange_hand: assert property (take && issue_instr[6:5] == 2'b00
    |=> exchange_op && !mem_req && !done) else $error("exchange not handed");
  a_imm_pre_addr: assert property (chk_q |-> mem_req && mem_addr == exp_q)
    else $error("bad address");
  a_store_repeat: assert property (mem_req && mem_write |-> mem_wdata[31:16] == mem_wdata[15:0])
    else $error("store halves differ");
  a_store_time: assert property (mem_req && mem_write |-> !issue_ready ##1 !issue_ready && !done
    ##1 done && issue_ready) else $error("store timing");
  a_load_busy: assert property (mem_req && !mem_write |-> !issue_ready [*3])
    else $error("load timing");
  a_abort_trap: assert property (mem_req ##1 mem_abort |=> abort_trap && done && !rd_we && !base_we)
    else $error("abort not taken");
  a_load_result: assert property (mem_req && !mem_write ##1 !mem_abort |=> rd_we)
    else $error("no load result");
endmodule // hsls_unit_assertions
`default_nettype wire

// ### hsls_unit_bench.sv
// Self-checking bench for the transfer unit with the memory model.
// Assumes the unit and checker are compiled before this file.
`default_nettype none
module hsls_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam DW = 32;
  logic mclk = 1'b0, resetn = 1'b0, endian_select_input = 1'b0, issue_valid = 1'b0, clr = 1'b0;
  logic [31:0] issue_instr = 32'h0, issue_addr = 32'h0, base_val = 32'h0;
  logic [31:0] offset_val = 32'h0, src_val = 32'h0, mem_rdata, mem_addr, mem_wdata, rd_data, base_data;
  logic [3:0] issue_flags = 4'h0, rd_idx, base_idx;
  logic issue_ready, mem_req, mem_write, mem_half, mem_abort, rd_we, base_we, abort_trap;
  logic exchange_op, done, seen_rd, seen_wb, seen_trap, seen_req;
  int fail_count = 0, tests_run = 0, last_n = 0;
  hsls_unit #(.DW(DW)) hsls_unit_inst (.mclk, .resetn, .endian_select_input, .issue_valid,
    .issue_instr, .issue_addr, .issue_flags, .base_val, .offset_val, .src_val, .issue_ready,
    .mem_req, .mem_write, .mem_half, .mem_addr, .mem_wdata, .mem_rdata, .mem_abort, .rd_we,
    .rd_idx, .rd_data, .base_we, .base_idx, .base_data, .abort_trap, .exchange_op, .done);
  hsls_mem_model hsls_mem_model_inst (.mclk, .big(endian_select_input), .mem_req, .mem_write,
    .mem_addr, .mem_wdata, .mem_rdata, .mem_abort);
  always #2 mclk = ~mclk;
  // Falling edge, so a pulse is captured while it still stands for the check
  always @(negedge mclk)
  begin
    seen_rd <= !clr & (seen_rd | rd_we);
    seen_wb <= !clr & (seen_wb | base_we);
    seen_trap <= !clr & (seen_trap | abort_trap);
    seen_req <= !clr & (seen_req | mem_req);
  end
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Callers keep W low when post-indexed, L high with S, halves aligned, offset reg not PC
  function automatic logic [31:0] mk(input logic [4:0] puiwl, input logic [1:0] sh,
    input logic [3:0] rn, input logic [3:0] rd, input logic [7:0] imm);
    return {4'hE, 3'b000, puiwl, rn, rd, imm[7:4], 1'b1, sh, 1'b1, imm[3:0]};
  endfunction
  task automatic run(input logic [31:0] ins, input logic [31:0] b, input logic [31:0] o,
    input logic [31:0] s);
    int n;
    @(posedge mclk);
    issue_instr <= ins;
    base_val <= b;
    offset_val <= o;
    src_val <= s;
    issue_valid <= 1'b1;
    clr <= 1'b1;
    @(posedge mclk);
    issue_valid <= 1'b0;
    clr <= 1'b0;
    n = 0;
    // A failed condition or exchange answers in the cycle right after the take
    #1;
    while (done !== 1'b1 && exchange_op !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    #2;
    last_n = n;
    if (n == 20)
    begin
      fail_count++;
      wrap_up();
    end
  endtask
  task automatic t_lanes();
    logic [31:0] w0, w2;
    logic [7:0] b;
    logic [15:0] h;
    w0 = 32'h80007F81;
    w2 = 32'hC3E51A96;
    for (int e = 0; e < 2; e++)
    begin
      @(posedge mclk);
      endian_select_input <= e[0];
      repeat (4) @(posedge mclk);
      for (int a = 0; a < 4; a++)
      begin
        run(mk(5'b11101, 2'b10, 4'h1, 4'h2, a[7:0]), 32'h0, 32'h0, 32'h0);
        b = w0[8 * (e ? 3 - a : a) +: 8];
        chk("byte", rd_data, {{24{b[7]}}, b});
        chk("no wb", {31'h0, seen_wb}, 32'h0);
      end
      for (int a = 0; a < 4; a += 2)
      begin
        h = (a[1] ^ e[0]) ? w2[31:16] : w2[15:0];
        run(mk(5'b11101, 2'b11, 4'h1, 4'h2, 8'h08 + a[7:0]), 32'h0, 32'h0, 32'h0);
        chk("shalf", rd_data, {{16{h[15]}}, h});
        run(mk(5'b11101, 2'b01, 4'h1, 4'h2, 8'h08 + a[7:0]), 32'h0, 32'h0, 32'h0);
        chk("uhalf", rd_data, {16'h0000, h});
      end
    end
    @(posedge mclk);
    endian_select_input <= 1'b0;
    repeat (4) @(posedge mclk);
    $display("end lanes");
  endtask
  task automatic t_store();
    run(mk(5'b11110, 2'b01, 4'h3, 4'h4, 8'h02), 32'h4, 32'h0, 32'h12349ABC);
    chk("st addr", mem_addr, 32'h6);
    chk("st data", mem_wdata, 32'h9ABC9ABC);
    chk("st wb", base_data, 32'h6);
    chk("st cycles", last_n, 32'h2);
    run(mk(5'b11101, 2'b11, 4'h3, 4'h4, 8'h06), 32'h0, 32'h0, 32'h0);
    chk("st back", rd_data, 32'hFFFF9ABC);
    chk("ld cycles", last_n, 32'h2);
    run(mk(5'b11101, 2'b01, 4'h3, 4'h4, 8'h04), 32'h0, 32'h0, 32'h0);
    chk("st other", rd_data, 32'h0);
    $display("end store");
  endtask
  task automatic t_index();
    run(mk(5'b00001, 2'b01, 4'h5, 4'h6, 8'h07), 32'hA, 32'h4, 32'h0);
    chk("post addr", mem_addr, 32'hA);
    chk("post data", rd_data, 32'h0000C3E5);
    chk("post wb", {31'h0, seen_wb}, 32'h1);
    chk("post base", base_data, 32'h6);
    run(mk(5'b11011, 2'b01, 4'h5, 4'h6, 8'h07), 32'h2, 32'h6, 32'h0);
    chk("pre addr", mem_addr, 32'h8);
    chk("pre base", base_data, 32'h8);
    $display("end index");
  endtask
  task automatic t_gate();
    logic [31:0] ins;
    @(posedge mclk);
    issue_flags <= 4'h4;
    ins = mk(5'b11101, 2'b01, 4'h1, 4'h2, 8'h00);
    ins[31:28] = 4'h1;
    run(ins, 32'h0, 32'h0, 32'h0);
    chk("ne skip", {31'h0, seen_req}, 32'h0);
    ins[31:28] = 4'h0;
    run(ins, 32'h0, 32'h0, 32'h0);
    chk("eq run", {31'h0, seen_rd}, 32'h1);
    run(mk(5'b11101, 2'b00, 4'h1, 4'h2, 8'h00), 32'h0, 32'h0, 32'h0);
    chk("exchange", {31'h0, exchange_op}, 32'h1);
    chk("exch req", {31'h0, seen_req}, 32'h0);
    run(mk(5'b11101, 2'b01, 4'h1, 4'h2, 8'h00), 32'h80, 32'h0, 32'h0);
    chk("trap", {30'h0, seen_trap, seen_rd}, 32'h2);
    $display("end gate");
  endtask
  task automatic t_pc();
    @(posedge mclk);
    issue_addr <= 32'h20;
    run(mk(5'b11101, 2'b01, 4'hF, 4'h2, 8'h00), 32'h0, 32'h0, 32'h0);
    chk("pc base", mem_addr, 32'h28);
    run(mk(5'b11100, 2'b01, 4'h1, 4'hF, 8'h0C), 32'h0, 32'h0, 32'h0);
    chk("pc src", mem_wdata, 32'h002C002C);
    run(mk(5'b11101, 2'b01, 4'h1, 4'hF, 8'h00), 32'h0, 32'h0, 32'h0);
    chk("pc rd idx", {28'h0, rd_idx}, 32'hF);
    chk("pc busy", {31'h0, issue_ready}, 32'h0);
    $display("end pc");
  endtask
  initial
  begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    t_lanes();
    t_store();
    t_index();
    t_gate();
    t_pc();
    wrap_up();
  end
endmodule // hsls_unit_bench
bind hsls_unit hsls_unit_assertions #(.DW(DW)) hsls_unit_assertions_inst (.mclk, .resetn,
  .issue_valid, .issue_ready, .issue_instr, .base_val, .mem_req, .mem_write, .mem_addr,
  .mem_wdata, .mem_abort, .rd_we, .base_we, .abort_trap, .exchange_op, .done);
`default_nettype wire
